// *** common/irq_bank2_pkg.sv ***
package irq_bank2_pkg;

  localparam int unsigned NUM_SRC = 5;

  // special-function register page and addresses
  localparam logic [7:0] PAGE_BANK2        = 8'h10;
  localparam logic [7:0] ADDR_ENABLE       = 8'he7;
  localparam logic [7:0] ADDR_PRIORITY_LO  = 8'hf4;
  localparam logic [7:0] ADDR_PRIORITY_HI  = 8'hf6;

  // source bit positions; both priority registers hold all five, the enable register only USB, VBUS and UART1
  localparam int unsigned BIT_USB    = 0;
  localparam int unsigned BIT_VBUS   = 1;
  localparam int unsigned BIT_UART1  = 2;
  localparam int unsigned BIT_I2C    = 3;
  localparam int unsigned BIT_TIMER4 = 4;

  localparam logic [7:0] RESET_ENABLE   = 8'h00;
  localparam logic [7:0] RESET_PRIORITY = 8'h00;
  localparam logic [7:0] MASK_ENABLE    = 8'h07;
  localparam logic [7:0] MASK_PRIORITY  = 8'h1f;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] source;
    logic [1:0] level;
  } irq_sel_type;

endpackage

// *** test/irq_bank2_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_bank2_checker #(parameter int unsigned NUM_SRC = 5) (
  input wire logic                       core_clk,
  input wire logic                       reset_n,
  input wire irq_bank2_pkg::sfr_req_type sfr_req,
  input wire logic [7:0]                 sfr_rdata,
  input wire logic [NUM_SRC-1:0]         src_request,
  input wire logic [1:0]                 ext_enable,
  input wire logic [NUM_SRC-1:0]         irq_pending,
  input wire irq_bank2_pkg::irq_sel_type irq_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire       pg = sfr_req.page == irq_bank2_pkg::PAGE_BANK2;
  logic [2:0] en_ff;
  logic [NUM_SRC-1:0] lo_ff;
  logic [NUM_SRC-1:0] hi_ff;
  logic [NUM_SRC-1:0] lo_d_ff;
  logic [NUM_SRC-1:0] hi_d_ff;
  logic               outranked;
  wire  [1:0]         win_level = {hi_d_ff[irq_sel.source], lo_d_ff[irq_sel.source]};
  // shadow of the enable bits, so gating is judged without the design's own copy
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) en_ff <= 3'h0;
    else if (sfr_req.wr_en && pg && sfr_req.addr == 8'he7) en_ff <= sfr_req.wdata[2:0];
  end
  // shadow priorities, plus a copy one cycle late that lines up with the registered winner
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_ff   <= '0;
      hi_ff   <= '0;
      lo_d_ff <= '0;
      hi_d_ff <= '0;
    end else begin
      if (sfr_req.wr_en && pg && sfr_req.addr == 8'hf4) lo_ff <= sfr_req.wdata[NUM_SRC-1:0];
      if (sfr_req.wr_en && pg && sfr_req.addr == 8'hf6) hi_ff <= sfr_req.wdata[NUM_SRC-1:0];
      lo_d_ff <= lo_ff;
      hi_d_ff <= hi_ff;
    end
  end
  always_comb begin
    outranked = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (irq_pending[i] && ({hi_d_ff[i], lo_d_ff[i]} > irq_sel.level
          || ({hi_d_ff[i], lo_d_ff[i]} == irq_sel.level && i < int'(irq_sel.source)))) begin
        outranked = 1'b1;
      end
    end
  end
  sequence wr_at(a); sfr_req.wr_en && pg && sfr_req.addr == a; endsequence
  sequence rd_at(a); sfr_req.rd_en && !sfr_req.wr_en && pg && sfr_req.addr == a; endsequence
  property back(a, m);
    wr_at(a) ##1 !sfr_req.wr_en ##1 rd_at(a) |=> sfr_rdata == ($past(sfr_req.wdata, 3) & m);
  endproperty
  chk_en_back: assert property (back(8'he7, 8'h07))
    else $error("enable readback");
  chk_lo_back: assert property (back(8'hf4, 8'h1f))
    else $error("low priority readback");
  chk_hi_back: assert property (back(8'hf6, 8'h1f))
    else $error("high priority readback");
  chk_uart_gate: assert property ($past(reset_n) |-> irq_pending[2] == $past(src_request[2] & en_ff[2]))
    else $error("uart gate");
  chk_vbus_gate: assert property ($past(reset_n) |-> irq_pending[1] == $past(src_request[1] & en_ff[1]))
    else $error("vbus gate");
  chk_usb_gate: assert property ($past(reset_n) |-> irq_pending[0] == $past(src_request[0] & en_ff[0]))
    else $error("usb gate");
  chk_sel_valid: assert property (irq_sel.valid == (|irq_pending))
    else $error("winner valid");
  chk_sel_pending: assert property (irq_sel.valid |-> irq_pending[irq_sel.source])
    else $error("winner not pending");
  chk_sel_level: assert property (irq_sel.valid |-> irq_sel.level == win_level)
    else $error("winner level");
  chk_sel_highest: assert property (irq_sel.valid |-> !outranked)
    else $error("winner outranked");
  chk_i2c_gate: assert property ($past(reset_n) |-> irq_pending[3] == $past(src_request[3] & ext_enable[0]))
    else $error("i2c gate");
  chk_timer_gate: assert property ($past(reset_n) |-> irq_pending[4] == $past(src_request[4] & ext_enable[1]))
    else $error("timer gate");
endmodule
`default_nettype wire

// *** test/irq_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// peripheral flags: level requests launched from the clock like real flag registers
module irq_src_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [4:0] raise,
  output var  logic [4:0] src_request
);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) src_request <= 5'h00;
    else src_request <= raise;
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                       core_clk = 1'b0;
  logic                       reset_n = 1'b0;
  irq_bank2_pkg::sfr_req_type req = '0;
  logic [7:0]                 sfr_rdata;
  logic [4:0]                 raise = 5'h00;
  logic [4:0]                 src_request;
  logic [1:0]                 ext_enable = 2'h0;
  logic [4:0]                 irq_pending;
  irq_bank2_pkg::irq_sel_type irq_sel;
  int                         err_total = 0;
  int                         comparisons = 0;
  always #2 core_clk = ~core_clk;
  irq_src_model src (.core_clk, .reset_n, .raise, .src_request);
  ext_irq_enable_priority_2 DUT (.core_clk, .reset_n, .sfr_req(req), .sfr_rdata, .src_request,
    .ext_enable, .irq_pending, .irq_sel);
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) req <= '{1'b1, 1'b0, 8'h10, a, d};
    @(posedge core_clk) req.wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk) req <= '{1'b0, 1'b1, p, a, 8'h00};
    @(posedge core_clk) req.rd_en <= 1'b0;
    #1 cmp(sfr_rdata, exp);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h10, 8'he7, 8'h00);
    rd(8'h10, 8'hf4, 8'h00);
    rd(8'h10, 8'hf6, 8'h00);
    wr(8'hf4, 8'h1f);
    rd(8'h10, 8'hf4, 8'h1f);
    wr(8'hf6, 8'h0a);
    rd(8'h10, 8'hf6, 8'h0a);
    rd(8'h00, 8'hf4, 8'h00);
    @(posedge core_clk) raise <= 5'h1f;
    for (int i = 0; i < 3; i++) begin
      wr(8'he7, 8'h01 << i);
      repeat (2) @(posedge core_clk);
      #1 cmp({3'h0, irq_pending}, 8'h01 << i);
    end
    @(posedge core_clk) ext_enable <= 2'h3;
    wr(8'he7, 8'hff);
    rd(8'h10, 8'he7, 8'h07);
    cmp({3'h0, irq_pending}, 8'h1f);
    cmp({2'h0, irq_sel}, 8'h27);
    wr(8'hf6, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 cmp({2'h0, irq_sel}, 8'h21);
    @(posedge core_clk) raise <= 5'h1e;
    repeat (2) @(posedge core_clk);
    #1 cmp({2'h0, irq_sel}, 8'h25);
    test_done();
  end
  // whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    test_done();
  end
endmodule
bind ext_irq_enable_priority_2 irq_bank2_checker #(.NUM_SRC(NUM_SRC)) chk (.core_clk, .reset_n, .sfr_req,
  .sfr_rdata, .src_request, .ext_enable, .irq_pending, .irq_sel);
`default_nettype wire

// *** verilog/ext_irq_enable_priority_2.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_irq_enable_priority_2 #(
  parameter int unsigned NUM_SRC = irq_bank2_pkg::NUM_SRC
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  input  wire irq_bank2_pkg::sfr_req_type  sfr_req,
  output var  logic [7:0]                  sfr_rdata,
  input  wire logic [NUM_SRC-1:0]          src_request,
  input  wire logic [1:0]                  ext_enable,
  output var  logic [NUM_SRC-1:0]          irq_pending,
  output var  irq_bank2_pkg::irq_sel_type  irq_sel
);

  // register select, decoded once and shared by the write and read paths
  typedef enum {
    SEL_NONE,
    SEL_ENABLE,
    SEL_PRIO_LO,
    SEL_PRIO_HI
  } reg_sel_type;

  logic [7:0]                 int_enable_bank2_ff;
  logic [7:0]                 nxt_int_enable_bank2;
  logic [7:0]                 int_priority_low_bank2_ff;
  logic [7:0]                 nxt_int_priority_low_bank2;
  logic [7:0]                 int_priority_high_bank2_ff;
  logic [7:0]                 nxt_int_priority_high_bank2;
  logic [7:0]                 sfr_rdata_ff;
  logic [7:0]                 nxt_sfr_rdata;
  logic [NUM_SRC-1:0]         irq_pending_ff;
  logic [NUM_SRC-1:0]         nxt_irq_pending;
  irq_bank2_pkg::irq_sel_type irq_sel_ff;
  irq_bank2_pkg::irq_sel_type nxt_irq_sel;
  reg_sel_type                reg_sel;
  logic                       page_hit;
  logic                       wr_enable_reg;
  logic                       wr_prio_lo;
  logic                       wr_prio_hi;
  logic [7:0]                 enable_wdata;
  logic [7:0]                 prio_wdata;
  logic [7:0]                 rd_word_enable;
  logic [7:0]                 rd_word_prio_lo;
  logic [7:0]                 rd_word_prio_hi;
  logic [NUM_SRC-1:0]         local_enable;
  logic [NUM_SRC-1:0]         gate;

  // all three registers share one page; any other page falls through to no select
  assign page_hit = sfr_req.page == irq_bank2_pkg::PAGE_BANK2;

  always_comb begin
    reg_sel = SEL_NONE;
    if (page_hit) begin
      case (sfr_req.addr)
        irq_bank2_pkg::ADDR_ENABLE: begin
          reg_sel = SEL_ENABLE;
        end
        irq_bank2_pkg::ADDR_PRIORITY_LO: begin
          reg_sel = SEL_PRIO_LO;
        end
        irq_bank2_pkg::ADDR_PRIORITY_HI: begin
          reg_sel = SEL_PRIO_HI;
        end
        default: begin
          reg_sel = SEL_NONE;
        end
      endcase
    end
  end

  assign wr_enable_reg = sfr_req.wr_en && reg_sel == SEL_ENABLE;
  assign wr_prio_lo    = sfr_req.wr_en && reg_sel == SEL_PRIO_LO;
  assign wr_prio_hi    = sfr_req.wr_en && reg_sel == SEL_PRIO_HI;

  // reserved bits dropped on the way in, so a careless write never sets them
  assign enable_wdata = sfr_req.wdata & irq_bank2_pkg::MASK_ENABLE;
  assign prio_wdata   = sfr_req.wdata & irq_bank2_pkg::MASK_PRIORITY;

  // enable group
  always_comb begin
    nxt_int_enable_bank2 = int_enable_bank2_ff;
    if (wr_enable_reg) begin
      nxt_int_enable_bank2 = enable_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_enable_bank2_ff <= irq_bank2_pkg::RESET_ENABLE;
    end else begin
      int_enable_bank2_ff <= nxt_int_enable_bank2;
    end
  end

  // low priority group
  always_comb begin
    nxt_int_priority_low_bank2 = int_priority_low_bank2_ff;
    if (wr_prio_lo) begin
      nxt_int_priority_low_bank2 = prio_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_priority_low_bank2_ff <= irq_bank2_pkg::RESET_PRIORITY;
    end else begin
      int_priority_low_bank2_ff <= nxt_int_priority_low_bank2;
    end
  end

  // high priority group
  always_comb begin
    nxt_int_priority_high_bank2 = int_priority_high_bank2_ff;
    if (wr_prio_hi) begin
      nxt_int_priority_high_bank2 = prio_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_priority_high_bank2_ff <= irq_bank2_pkg::RESET_PRIORITY;
    end else begin
      int_priority_high_bank2_ff <= nxt_int_priority_high_bank2;
    end
  end

  // reserved bits always read as zero
  assign rd_word_enable  = int_enable_bank2_ff & irq_bank2_pkg::MASK_ENABLE;
  assign rd_word_prio_lo = int_priority_low_bank2_ff & irq_bank2_pkg::MASK_PRIORITY;
  assign rd_word_prio_hi = int_priority_high_bank2_ff & irq_bank2_pkg::MASK_PRIORITY;

  // read group: a write in the same cycle is not seen until the next read
  always_comb begin
    nxt_sfr_rdata = sfr_rdata_ff;
    if (sfr_req.rd_en) begin
      case (reg_sel)
        SEL_ENABLE: begin
          nxt_sfr_rdata = rd_word_enable;
        end
        SEL_PRIO_LO: begin
          nxt_sfr_rdata = rd_word_prio_lo;
        end
        SEL_PRIO_HI: begin
          nxt_sfr_rdata = rd_word_prio_hi;
        end
        default: begin
          nxt_sfr_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_ff <= '0;
    end else begin
      sfr_rdata_ff <= nxt_sfr_rdata;
    end
  end

  // timer 4 and i2c slave enables live in a neighbouring register, so they arrive as inputs
  always_comb begin
    local_enable                            = '0;
    local_enable[irq_bank2_pkg::BIT_USB]    = int_enable_bank2_ff[irq_bank2_pkg::BIT_USB];
    local_enable[irq_bank2_pkg::BIT_VBUS]   = int_enable_bank2_ff[irq_bank2_pkg::BIT_VBUS];
    local_enable[irq_bank2_pkg::BIT_UART1]  = int_enable_bank2_ff[irq_bank2_pkg::BIT_UART1];
    local_enable[irq_bank2_pkg::BIT_I2C]    = ext_enable[0];
    local_enable[irq_bank2_pkg::BIT_TIMER4] = ext_enable[1];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gen_gate
      assign gate[g] = src_request[g] & local_enable[g];
    end
  endgenerate

  // pending group
  always_comb begin
    nxt_irq_pending = gate;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pending_ff <= '0;
    end else begin
      irq_pending_ff <= nxt_irq_pending;
    end
  end

  // selection group: judged on the same vector that is registered as pending, so both agree
  irq_bank2_arbiter #(
    .NUM_SRC (NUM_SRC)
  ) u_arbiter (
    .request (nxt_irq_pending),
    .prio_lo (int_priority_low_bank2_ff[NUM_SRC-1:0]),
    .prio_hi (int_priority_high_bank2_ff[NUM_SRC-1:0]),
    .sel     (nxt_irq_sel)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_sel_ff <= '0;
    end else begin
      irq_sel_ff <= nxt_irq_sel;
    end
  end

  assign sfr_rdata   = sfr_rdata_ff;
  assign irq_pending = irq_pending_ff;
  assign irq_sel     = irq_sel_ff;

endmodule
`default_nettype wire

// *** verilog/irq_bank2_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_bank2_arbiter #(
  parameter int unsigned NUM_SRC = 5
) (
  input  wire logic [NUM_SRC-1:0] request,
  input  wire logic [NUM_SRC-1:0] prio_lo,
  input  wire logic [NUM_SRC-1:0] prio_hi,
  output var  irq_bank2_pkg::irq_sel_type sel
);

  logic [1:0] level [NUM_SRC];

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gen_level
      assign level[g] = {prio_hi[g], prio_lo[g]};
    end
  endgenerate

  // scan upward with strict compare: lowest index wins a tie
  always_comb begin
    sel = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (request[i] && (!sel.valid || level[i] > sel.level)) begin
        sel.valid  = 1'b1;
        sel.source = 3'(i);
        sel.level  = level[i];
      end
    end
  end

endmodule
`default_nettype wire
